//--- core/cbf_exec.sv
// Function
// - branch when interrupt flag set: pc gets pc+offset+1, 1/2 cycles, no flags
// - branch when interrupt flag clear: pc gets pc+offset+1, 1/2 cycles, no flags
// - io bit set/clear forces one bit, others kept, no flags, two cycles
// - left shift inserts zero at bit 0, updates Z C N V, one cycle
// - right shift inserts zero at bit 7, updates Z C N V, one cycle
// - rotate left: carry into bit 0, bit 7 into carry, Z C N V
// - rotate right: carry into bit 7, bit 0 into carry, Z C N V
// - arithmetic shift keeps bit 7, updates flags; nibble swap keeps flags; one cycle
// - bit store copies register bit into transfer flag only, one cycle
// - bit load writes transfer flag into register bit, no flags, one cycle
// - signed flag set and clear, only that flag, one cycle
// - overflow flag set and clear, only that flag, one cycle
// - half carry flag set and clear, only that flag, one cycle
// - post-increment load reads at pointer then adds one, two cycles
// - pre-decrement load subtracts one then reads, two cycles
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module cbf_exec (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic instr_valid_in,
    input wire cbf_pkg::cbf_instr_t instr_in,
    output logic instr_ready_out,
    output logic [15:0] pc_out,
    output logic [7:0] stat_out,
    output cbf_pkg::cbf_dmem_req_t dmem_req_out,
    input wire logic [7:0] dmem_rdata_in,
    output cbf_pkg::cbf_io_req_t io_req_out,
    input wire logic [7:0] io_rdata_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out
);
    import cbf_pkg::*;

    cbf_st_t st_ff;
    cbf_st_t nxt_st;

    logic accept;
    assign instr_ready_out = (st_ff.state == CBF_ST_IDLE) && st_ff.run;
    assign accept = instr_valid_in && instr_ready_out;
    assign pc_out = st_ff.pc;
    assign stat_out = st_ff.stat;
    assign dmem_req_out = st_ff.dmem;
    assign io_req_out = st_ff.io;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st_ff.hrdata;

    always_comb
    begin
        logic [7:0] src_d;
        logic [7:0] src_r;
        logic [7:0] res;
        logic cy;
        logic [4:0] plo;
        logic [15:0] ptr;
        logic [15:0] addr;
        logic [15:0] ptr_new;
        logic [7:0] mask;
        src_d = 8'h00;
        src_r = 8'h00;
        res = 8'h00;
        cy = 1'b0;
        plo = CBF_PTR_X_LO;
        ptr = 16'h0000;
        addr = 16'h0000;
        ptr_new = 16'h0000;
        mask = 8'h00;
        nxt_st = st_ff;
        nxt_st.dmem.rd = 1'b0;
        nxt_st.io.rd = 1'b0;
        nxt_st.io.wr = 1'b0;

        // bus address phase capture and read data
        nxt_st.bus_act = hsel_in && hready_in && htrans_in[1];
        if (hsel_in && hready_in && htrans_in[1])
        begin
            nxt_st.bus_wr = hwrite_in;
            nxt_st.bus_addr = haddr_in[7:0];
            case (haddr_in[7:0])
                CBF_CTRL_OFS: nxt_st.hrdata = {31'h0000_0000, st_ff.run};
                CBF_STAT_OFS: nxt_st.hrdata = {24'h00_0000, st_ff.stat};
                CBF_PC_OFS: nxt_st.hrdata = {16'h0000, st_ff.pc};
                default: nxt_st.hrdata = 32'h0000_0000;
            endcase
        end
        // bus data phase write; pc and flags only while halted
        if (st_ff.bus_act && st_ff.bus_wr)
        begin
            case (st_ff.bus_addr)
                CBF_CTRL_OFS: nxt_st.run = hwdata_in[CBF_CTRL_RUN_BIT];
                CBF_STAT_OFS:
                begin
                    if (!st_ff.run)
                        nxt_st.stat = hwdata_in[7:0];
                end
                CBF_PC_OFS:
                begin
                    if (!st_ff.run)
                        nxt_st.pc = hwdata_in[15:0];
                end
                default: ;
            endcase
        end

        src_d = st_ff.regs[instr_in.rd];
        src_r = st_ff.regs[instr_in.rr];
        case (instr_in.ptr_sel)
            cbf_ptr_y: plo = CBF_PTR_Y_LO;
            cbf_ptr_z: plo = CBF_PTR_Z_LO;
            default: plo = CBF_PTR_X_LO;
        endcase
        ptr = {st_ff.regs[plo + 5'h01], st_ff.regs[plo]};

        case (st_ff.state)
            CBF_ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_st.pc = st_ff.pc + 16'h0001;
                    case (instr_in.op)
                        branch_on_int_enabled, branch_on_int_disabled:
                        begin
                            if (st_ff.stat[CBF_FLAG_I] == (instr_in.op == branch_on_int_enabled))
                            begin
                                nxt_st.pc = st_ff.pc + 16'h0001
                                    + {{9{instr_in.offset[6]}}, instr_in.offset};
                                nxt_st.state = CBF_ST_BRANCH;
                            end
                        end
                        io_bit_set_op, io_bit_clear_op:
                        begin
                            nxt_st.io.rd = 1'b1;
                            nxt_st.io.addr = instr_in.io_addr;
                            nxt_st.io_set = (instr_in.op == io_bit_set_op);
                            nxt_st.io_bit = instr_in.bit_sel;
                            nxt_st.state = CBF_ST_IO;
                        end
                        logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
                        rotate_right_carry_op, arith_right_shift_op:
                        begin
                            case (instr_in.op)
                                logical_left_shift_op:
                                begin
                                    res = {src_d[6:0], 1'b0};
                                    cy = src_d[7];
                                end
                                logical_right_shift_op:
                                begin
                                    res = {1'b0, src_d[7:1]};
                                    cy = src_d[0];
                                end
                                rotate_left_carry_op:
                                begin
                                    res = {src_d[6:0], st_ff.stat[CBF_FLAG_C]};
                                    cy = src_d[7];
                                end
                                rotate_right_carry_op:
                                begin
                                    res = {st_ff.stat[CBF_FLAG_C], src_d[7:1]};
                                    cy = src_d[0];
                                end
                                default:
                                begin
                                    res = {src_d[7], src_d[7:1]};
                                    cy = src_d[0];
                                end
                            endcase
                            nxt_st.regs[instr_in.rd] = res;
                            nxt_st.stat[CBF_FLAG_Z] = (res == 8'h00);
                            nxt_st.stat[CBF_FLAG_C] = cy;
                            nxt_st.stat[CBF_FLAG_N] = res[7];
                            nxt_st.stat[CBF_FLAG_V] = res[7] ^ cy;
                        end
                        nibble_swap_op:
                            nxt_st.regs[instr_in.rd] = {src_d[3:0], src_d[7:4]};
                        bit_to_transfer_flag_op:
                            nxt_st.stat[CBF_FLAG_T] = src_r[instr_in.bit_sel];
                        transfer_flag_to_bit_op:
                            nxt_st.regs[instr_in.rd][instr_in.bit_sel] =
                                st_ff.stat[CBF_FLAG_T];
                        flag_set_op: nxt_st.stat[instr_in.bit_sel] = 1'b1;
                        flag_clear_op: nxt_st.stat[instr_in.bit_sel] = 1'b0;
                        signed_flag_set_op: nxt_st.stat[CBF_FLAG_S] = 1'b1;
                        signed_flag_clear_op: nxt_st.stat[CBF_FLAG_S] = 1'b0;
                        overflow_flag_set_op: nxt_st.stat[CBF_FLAG_V] = 1'b1;
                        overflow_flag_clear_op: nxt_st.stat[CBF_FLAG_V] = 1'b0;
                        half_carry_set_op: nxt_st.stat[CBF_FLAG_H] = 1'b1;
                        half_carry_clear_op: nxt_st.stat[CBF_FLAG_H] = 1'b0;
                        global_int_enable_op: nxt_st.stat[CBF_FLAG_I] = 1'b1;
                        global_int_disable_op: nxt_st.stat[CBF_FLAG_I] = 1'b0;
                        register_move_op: nxt_st.regs[instr_in.rd] = src_r;
                        register_pair_copy_op:
                        begin
                            nxt_st.regs[{instr_in.rd[4:1], 1'b0}] =
                                st_ff.regs[{instr_in.rr[4:1], 1'b0}];
                            nxt_st.regs[{instr_in.rd[4:1], 1'b1}] =
                                st_ff.regs[{instr_in.rr[4:1], 1'b1}];
                        end
                        immediate_load_op: nxt_st.regs[instr_in.rd] = instr_in.imm;
                        indirect_load_op:
                        begin
                            case (instr_in.ptr_mode)
                                cbf_ptr_post_inc:
                                begin
                                    addr = ptr;
                                    ptr_new = ptr + 16'h0001;
                                end
                                cbf_ptr_pre_dec:
                                begin
                                    addr = ptr - 16'h0001;
                                    ptr_new = addr;
                                end
                                default:
                                begin
                                    addr = ptr;
                                    ptr_new = ptr;
                                end
                            endcase
                            nxt_st.regs[plo] = ptr_new[7:0];
                            nxt_st.regs[plo + 5'h01] = ptr_new[15:8];
                            nxt_st.dmem.rd = 1'b1;
                            nxt_st.dmem.addr = addr;
                            nxt_st.load_rd = instr_in.rd;
                            nxt_st.state = CBF_ST_LOAD;
                        end
                        default: ;
                    endcase
                end
            end
            CBF_ST_BRANCH: nxt_st.state = CBF_ST_IDLE;
            CBF_ST_LOAD:
            begin
                // read data is valid while the read strobe stands
                nxt_st.regs[st_ff.load_rd] = dmem_rdata_in;
                nxt_st.state = CBF_ST_IDLE;
            end
            CBF_ST_IO:
            begin
                mask = 8'h01 << st_ff.io_bit;
                nxt_st.io.wr = 1'b1;
                nxt_st.io.wdata = st_ff.io_set ? (io_rdata_in | mask)
                    : (io_rdata_in & ~mask);
                nxt_st.state = CBF_ST_IDLE;
            end
            default: nxt_st.state = CBF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_ff <= '0;
            st_ff.regs <= {32{CBF_REG_RST}};
            st_ff.stat <= CBF_STAT_RST;
            st_ff.pc <= CBF_PC_RST;
            st_ff.run <= CBF_RUN_RST;
            st_ff.state <= CBF_ST_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule

//--- core/cbf_pkg.sv
package cbf_pkg;
    // bus register byte offsets
    localparam logic [7:0] CBF_CTRL_OFS = 8'h00;
    localparam logic [7:0] CBF_STAT_OFS = 8'h04;
    localparam logic [7:0] CBF_PC_OFS = 8'h08;
    localparam int CBF_CTRL_RUN_BIT = 0;
    localparam logic CBF_RUN_RST = 1'b1;
    localparam logic [15:0] CBF_PC_RST = 16'h0000;
    localparam logic [7:0] CBF_STAT_RST = 8'h00;
    localparam logic [7:0] CBF_REG_RST = 8'h00;
    // status flag bit positions
    localparam logic [2:0] CBF_FLAG_C = 3'h0;
    localparam logic [2:0] CBF_FLAG_Z = 3'h1;
    localparam logic [2:0] CBF_FLAG_N = 3'h2;
    localparam logic [2:0] CBF_FLAG_V = 3'h3;
    localparam logic [2:0] CBF_FLAG_S = 3'h4;
    localparam logic [2:0] CBF_FLAG_H = 3'h5;
    localparam logic [2:0] CBF_FLAG_T = 3'h6;
    localparam logic [2:0] CBF_FLAG_I = 3'h7;
    // low register of each pointer pair
    localparam logic [4:0] CBF_PTR_X_LO = 5'h1A;
    localparam logic [4:0] CBF_PTR_Y_LO = 5'h1C;
    localparam logic [4:0] CBF_PTR_Z_LO = 5'h1E;

    typedef enum logic [5:0] {
        cbf_nop_op,
        branch_on_int_enabled,
        branch_on_int_disabled,
        io_bit_set_op,
        io_bit_clear_op,
        logical_left_shift_op,
        logical_right_shift_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        arith_right_shift_op,
        nibble_swap_op,
        bit_to_transfer_flag_op,
        transfer_flag_to_bit_op,
        flag_set_op,
        flag_clear_op,
        signed_flag_set_op,
        signed_flag_clear_op,
        overflow_flag_set_op,
        overflow_flag_clear_op,
        half_carry_set_op,
        half_carry_clear_op,
        global_int_enable_op,
        global_int_disable_op,
        register_move_op,
        register_pair_copy_op,
        immediate_load_op,
        indirect_load_op
    } cbf_op_t;

    typedef enum logic [1:0] {cbf_ptr_x, cbf_ptr_y, cbf_ptr_z} cbf_ptr_sel_t;
    typedef enum logic [1:0] {cbf_ptr_plain, cbf_ptr_post_inc, cbf_ptr_pre_dec} cbf_ptr_mode_t;
    typedef enum {CBF_ST_IDLE, CBF_ST_BRANCH, CBF_ST_LOAD, CBF_ST_IO} cbf_state_t;

    typedef struct packed {
        cbf_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic [6:0] offset;
        logic [4:0] io_addr;
        cbf_ptr_sel_t ptr_sel;
        cbf_ptr_mode_t ptr_mode;
    } cbf_instr_t;

    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } cbf_dmem_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } cbf_io_req_t;

    typedef struct packed {
        logic [31:0][7:0] regs;
        logic [7:0] stat;
        logic [15:0] pc;
        logic run;
        cbf_state_t state;
        logic [4:0] load_rd;
        logic io_set;
        logic [2:0] io_bit;
        cbf_dmem_req_t dmem;
        cbf_io_req_t io;
        logic bus_act;
        logic bus_wr;
        logic [7:0] bus_addr;
        logic [31:0] hrdata;
    } cbf_st_t;
endpackage

//--- sim/cbf_mem_model.sv
`timescale 1ns/1ps
module cbf_mem_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire cbf_pkg::cbf_dmem_req_t dmem_in,
    output logic [7:0] dmem_out,
    input wire cbf_pkg::cbf_io_req_t io_in,
    output logic [7:0] io_out
);
    import cbf_pkg::*;
    logic [7:0] io_ff [32];
    logic [7:0] junk_ff;
    // answer only while strobed, else a moving pattern
    assign dmem_out = dmem_in.rd ? (dmem_in.addr[7:0] ^ dmem_in.addr[15:8] ^ 8'h3C) : junk_ff;
    assign io_out = io_in.rd ? io_ff[io_in.addr] : ~junk_ff;
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            junk_ff <= 8'h00;
            for (int i = 0; i < 32; i++)
                io_ff[i] <= {3'b101, 5'(i)};
        end
        else
        begin
            junk_ff <= junk_ff + 8'h5B;
            if (io_in.wr)
                io_ff[io_in.addr] <= io_in.wdata;
        end
    end
endmodule

//--- sim/cbf_exec_sva.sv
`timescale 1ns/1ps
module cbf_exec_sva (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic instr_valid_in,
    input wire cbf_pkg::cbf_instr_t instr_in,
    input wire logic instr_ready_out,
    input wire logic [15:0] pc_out,
    input wire logic [7:0] stat_out,
    input wire cbf_pkg::cbf_dmem_req_t dmem_req_out,
    input wire cbf_pkg::cbf_io_req_t io_req_out,
    input wire logic [7:0] io_rdata_in
);
    import cbf_pkg::*;
    logic acc;
    logic [15:0] ofs;
    logic [7:0] bm;
    logic [2:0] fi;
    cbf_op_t op;
    assign op = instr_in.op;
    assign acc = instr_valid_in && instr_ready_out;
    assign ofs = {{9{instr_in.offset[6]}}, instr_in.offset};
    assign bm = 8'h01 << instr_in.bit_sel;
    always_comb
    begin
        case (op)
            signed_flag_set_op, signed_flag_clear_op: fi = CBF_FLAG_S;
            overflow_flag_set_op, overflow_flag_clear_op: fi = CBF_FLAG_V;
            half_carry_set_op, half_carry_clear_op: fi = CBF_FLAG_H;
            global_int_enable_op, global_int_disable_op: fi = CBF_FLAG_I;
            default: fi = instr_in.bit_sel;
        endcase
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    chk_int_on_taken: assert property (acc &&
        op == branch_on_int_enabled && stat_out[7] |=>
        pc_out == $past(pc_out) + $past(ofs) + 16'h0001 && !instr_ready_out)
        else $error("taken branch on enabled wrong");
    chk_int_off_taken: assert property (acc &&
        op == branch_on_int_disabled && !stat_out[7] |=>
        pc_out == $past(pc_out) + $past(ofs) + 16'h0001 && !instr_ready_out)
        else $error("taken branch on disabled wrong");
    chk_branch_fall: assert property (acc &&
        ((op == branch_on_int_enabled && !stat_out[7]) ||
        (op == branch_on_int_disabled && stat_out[7])) |=> pc_out == $past(pc_out) + 16'h0001
        && stat_out == $past(stat_out) && instr_ready_out) else $error("branch fall through wrong");
    chk_io_rmw: assert property (acc && op inside {io_bit_set_op, io_bit_clear_op} |=>
        io_req_out.rd && io_req_out.addr == $past(instr_in.io_addr) ##1 io_req_out.wr
        && io_req_out.wdata == (($past(op, 2) == io_bit_set_op)
        ? ($past(io_rdata_in) | $past(bm, 2)) : ($past(io_rdata_in) & ~$past(bm, 2)))
        && $stable(stat_out)) else $error("io bit op wrong");
    chk_shift_flags: assert property (acc &&
        op inside {logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
        rotate_right_carry_op, arith_right_shift_op}
        |=> stat_out[3] == (stat_out[2] ^ stat_out[0]) && stat_out[7:4] == $past(stat_out[7:4])
        && instr_ready_out) else $error("shift flags wrong");
    chk_swap_keep: assert property (acc && op == nibble_swap_op |=> stat_out == $past(stat_out))
        else $error("swap touched flags");
    chk_tstore_only: assert property (acc && op == bit_to_transfer_flag_op |=>
        (stat_out & 8'hBF) == ($past(stat_out) & 8'hBF) && instr_ready_out)
        else $error("bit store touched other flags");
    chk_single_cycle: assert property (acc && op inside {transfer_flag_to_bit_op,
        register_move_op, register_pair_copy_op, immediate_load_op} |=> instr_ready_out
        && stat_out == $past(stat_out) && pc_out == $past(pc_out) + 16'h0001)
        else $error("single cycle op wrong");
    chk_flag_set: assert property (acc &&
        op inside {flag_set_op, signed_flag_set_op,
        overflow_flag_set_op, half_carry_set_op, global_int_enable_op}
        |=> stat_out == ($past(stat_out) | (8'h01 << $past(fi)))) else $error("flag set wrong");
    chk_flag_clear: assert property (acc &&
        op inside {flag_clear_op, signed_flag_clear_op,
        overflow_flag_clear_op, half_carry_clear_op, global_int_disable_op}
        |=> stat_out == ($past(stat_out) & ~(8'h01 << $past(fi)))) else $error("flag clear wrong");
    chk_load_two: assert property (acc &&
        op == indirect_load_op |=> dmem_req_out.rd
        && !instr_ready_out && $stable(stat_out) ##1 !dmem_req_out.rd) else $error("load timing wrong");
endmodule
bind cbf_exec cbf_exec_sva u_sva (.clk_in, .rstn_in, .instr_valid_in, .instr_in, .instr_ready_out,
    .pc_out, .stat_out, .dmem_req_out, .io_req_out, .io_rdata_in);

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) fail(nm, e, g); end
module tb;
    import cbf_pkg::*;
    logic clk_in = 1'b0, rstn_in = 1'b0, instr_valid_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic instr_ready_out, hreadyout_out, hresp_out;
    cbf_instr_t instr_in = '0;
    cbf_dmem_req_t dmem_req_out;
    cbf_io_req_t io_req_out;
    logic [15:0] pc_out, exp_pc = 16'h0000;
    logic [7:0] stat_out, dmem_rdata_in, io_rdata_in, exp_stat, v;
    logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out, rd;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2;
    int bad_count = 0, check_count = 0;
    localparam cbf_op_t FSET [8] = '{flag_set_op, flag_set_op, flag_set_op, overflow_flag_set_op,
        signed_flag_set_op, half_carry_set_op, flag_set_op, global_int_enable_op};
    localparam cbf_op_t FCLR [8] = '{flag_clear_op, flag_clear_op, flag_clear_op,
        overflow_flag_clear_op, signed_flag_clear_op, half_carry_clear_op, flag_clear_op,
        global_int_disable_op};
    localparam cbf_op_t AOP [9] = '{logical_left_shift_op, logical_right_shift_op,
        logical_right_shift_op, rotate_left_carry_op, rotate_right_carry_op, arith_right_shift_op,
        nibble_swap_op, bit_to_transfer_flag_op, transfer_flag_to_bit_op};
    localparam logic [7:0] ARES [9] = '{8'h02, 8'h40, 8'h00, 8'h03, 8'hC0, 8'hC0, 8'h18, 8'h81, 8'h89};
    localparam logic [7:0] AFL [9] = '{8'h09, 8'h09, 8'h0B, 8'h09, 8'h05, 8'h05, 8'h01, 8'h41, 8'h41};
    localparam logic [1:0] LMOD [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    localparam logic [15:0] LADR [4] = '{16'h0110, 16'h0111, 16'h0110, 16'h0220};
    always #12.5 clk_in = ~clk_in;
    cbf_exec u_dut (.clk_in, .rstn_in, .instr_valid_in, .instr_in, .instr_ready_out, .pc_out,
        .stat_out, .dmem_req_out, .dmem_rdata_in, .io_req_out, .io_rdata_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out,
        .hresp_out, .hrdata_out);
    cbf_mem_model u_mem (.clk_in, .rstn_in, .dmem_in(dmem_req_out), .dmem_out(dmem_rdata_in),
        .io_in(io_req_out), .io_out(io_rdata_in));
    task automatic close_out();
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic fail(input string nm, input logic [31:0] e, input logic [31:0] g);
        bad_count++;
        $display("FAIL %s exp %0h got %0h", nm, e, g);
    endtask
    task automatic hang();
        bad_count++;
        close_out();
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge clk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= {24'h0, a};
        @(posedge clk_in);
        for (n = 0; hreadyout_out !== 1'b1 && n < 20; n++) @(posedge clk_in);
        if (n >= 20) hang();
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge clk_in);
        for (n = 0; hreadyout_out !== 1'b1 && n < 20; n++) @(posedge clk_in);
        r = hrdata_out;
        if (n >= 20) hang();
        `CHK("resp", 1'b0, hresp_out)
    endtask
    function automatic cbf_instr_t mk(cbf_op_t o, logic [4:0] d, logic [4:0] s, logic [2:0] b,
        logic [7:0] k);
        mk = '{o, d, s, b, k, k[6:0], d, cbf_ptr_sel_t'(s[1:0]), cbf_ptr_mode_t'(b[1:0])};
    endfunction
    task automatic issue(input cbf_instr_t i, input logic busy);
        int n;
        @(posedge clk_in);
        instr_in <= i;
        instr_valid_in <= 1'b1;
        @(negedge clk_in);
        for (n = 0; instr_ready_out !== 1'b1 && n < 50; n++) @(negedge clk_in);
        if (n >= 50) hang();
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        exp_pc = exp_pc + 16'h0001;
        if (busy && i.op inside {branch_on_int_enabled, branch_on_int_disabled})
            exp_pc = exp_pc + {{9{i.offset[6]}}, i.offset};
        @(negedge clk_in);
        `CHK("ready", !busy, instr_ready_out)
        `CHK("pc", exp_pc, pc_out)
    endtask
    task automatic read_reg(input logic [4:0] r, output logic [7:0] val);
        for (int k = 0; k < 8; k++)
        begin
            issue(mk(bit_to_transfer_flag_op, 5'h00, r, 3'(k), 8'h00), 1'b0);
            val[k] = stat_out[CBF_FLAG_T];
        end
    endtask
    task automatic t_bus();
        ahb(1'b0, CBF_CTRL_OFS, 32'h0, rd);
        `CHK("ctrl", 32'h1, rd)
        ahb(1'b0, CBF_STAT_OFS, 32'h0, rd);
        `CHK("stat", 32'h0, rd)
        ahb(1'b1, CBF_PC_OFS, 32'h1234, rd);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        ahb(1'b0, CBF_PC_OFS, 32'h0, rd);
        `CHK("pc locked", 32'h0, rd)
        ahb(1'b1, CBF_CTRL_OFS, 32'h0, rd);
        ahb(1'b1, CBF_PC_OFS, 32'h0040, rd);
        @(negedge clk_in);
        `CHK("halted ready", 1'b0, instr_ready_out)
        ahb(1'b0, CBF_PC_OFS, 32'h0, rd);
        `CHK("pc written", 32'h40, rd)
        exp_pc = 16'h0040;
        ahb(1'b1, CBF_CTRL_OFS, 32'h1, rd);
    endtask
    task automatic t_flags();
        exp_stat = 8'h00;
        for (int p = 0; p < 2; p++)
            for (int f = 0; f < 8; f++)
            begin
                issue(mk(p ? FCLR[f] : FSET[f], 5'h00, 5'h00, 3'(f), 8'h00), 1'b0);
                exp_stat[f] = !p;
                `CHK("flags", exp_stat, stat_out)
            end
    endtask
    task automatic t_branch();
        issue(mk(branch_on_int_enabled, 5'h00, 5'h00, 3'h0, 8'h05), 1'b0);
        issue(mk(branch_on_int_disabled, 5'h00, 5'h00, 3'h0, 8'h7D), 1'b1);
        issue(mk(global_int_enable_op, 5'h00, 5'h00, 3'h0, 8'h00), 1'b0);
        issue(mk(branch_on_int_enabled, 5'h00, 5'h00, 3'h0, 8'h05), 1'b1);
        issue(mk(branch_on_int_disabled, 5'h00, 5'h00, 3'h0, 8'h05), 1'b0);
        `CHK("branch flags", 8'h80, stat_out)
        issue(mk(global_int_disable_op, 5'h00, 5'h00, 3'h0, 8'h00), 1'b0);
    endtask
    task automatic t_alu();
        for (int i = 0; i < 9; i++)
        begin
            ahb(1'b1, CBF_CTRL_OFS, 32'h0, rd);
            ahb(1'b1, CBF_STAT_OFS, (i == 8) ? 32'h41 : 32'h01, rd);
            ahb(1'b1, CBF_CTRL_OFS, 32'h1, rd);
            issue(mk(immediate_load_op, 5'h10, 5'h10, 3'h0, (i == 2) ? 8'h01 : 8'h81), 1'b0);
            issue(mk(AOP[i], 5'h10, 5'h10, (i == 7) ? 3'h7 : 3'h3, 8'h00), 1'b0);
            `CHK("alu flags", AFL[i], stat_out)
            read_reg(5'h10, v);
            `CHK("alu result", ARES[i], v)
        end
    endtask
    task automatic t_move();
        issue(mk(immediate_load_op, 5'h10, 5'h00, 3'h0, 8'h5A), 1'b0);
        issue(mk(immediate_load_op, 5'h11, 5'h00, 3'h0, 8'hC3), 1'b0);
        issue(mk(register_move_op, 5'h04, 5'h11, 3'h0, 8'h00), 1'b0);
        issue(mk(register_pair_copy_op, 5'h02, 5'h10, 3'h0, 8'h00), 1'b0);
        read_reg(5'h04, v);
        `CHK("move", 8'hC3, v)
        read_reg(5'h02, v);
        `CHK("pair low", 8'h5A, v)
        read_reg(5'h03, v);
        `CHK("pair high", 8'hC3, v)
    endtask
    task automatic t_load();
        logic [15:0] a;
        issue(mk(immediate_load_op, 5'h1A, 5'h00, 3'h0, 8'h10), 1'b0);
        issue(mk(immediate_load_op, 5'h1B, 5'h00, 3'h0, 8'h01), 1'b0);
        issue(mk(immediate_load_op, 5'h1C, 5'h00, 3'h0, 8'h20), 1'b0);
        issue(mk(immediate_load_op, 5'h1D, 5'h00, 3'h0, 8'h02), 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            a = LADR[i];
            issue(mk(indirect_load_op, 5'h05, (i == 3) ? 5'h01 : 5'h00, {1'b0, LMOD[i]}, 8'h00), 1'b1);
            `CHK("load strobe", 1'b1, dmem_req_out.rd)
            `CHK("load addr", a, dmem_req_out.addr)
            read_reg(5'h05, v);
            `CHK("load data", a[7:0] ^ a[15:8] ^ 8'h3C, v)
        end
    endtask
    task automatic t_io();
        for (int i = 0; i < 2; i++)
        begin
            issue(mk(i ? io_bit_clear_op : io_bit_set_op, 5'h09, 5'h00, i ? 3'h7 : 3'h2, 8'h00), 1'b1);
            `CHK("io read", 1'b1, io_req_out.rd)
            `CHK("io addr", 5'h09, io_req_out.addr)
            @(negedge clk_in);
            `CHK("io write", 1'b1, io_req_out.wr)
            `CHK("io data", i ? 8'h2D : 8'hAD, io_req_out.wdata)
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_bus();
        t_flags();
        t_branch();
        t_alu();
        t_move();
        t_load();
        t_io();
        close_out();
    end
endmodule
